//--- rtl/mbcd_cfg.svh
// Register offsets, field positions, reset values and timing counts for the bias detect block
`ifndef MBCD_CFG_SVH
`define MBCD_CFG_SVH

// Register offsets (word index on the plain register port)
`define MBCD_OFF_CTRL      8'h06
`define MBCD_OFF_VSEL      8'h07
`define MBCD_OFF_IRQCFG    8'h08
`define MBCD_OFF_STATUS    8'h09
`define MBCD_OFF_MASK      8'h0A
`define MBCD_OFF_CLKCFG    8'h0B
`define MBCD_OFF_STATE     8'h0C

// Field positions in the primary control register
`define MBCD_BIT_BIAS_EN   0
`define MBCD_BIT_DET_EN    1
`define MBCD_SHT_LO        2
`define MBCD_SHT_HI        3
`define MBCD_INS_LO        4
`define MBCD_INS_HI        6

// Field positions in the interrupt config, status, mask and state registers
`define MBCD_BIT_INS       0
`define MBCD_BIT_HOOK      1

// Field positions in the clocking register
`define MBCD_BIT_MCLK_OK   0
`define MBCD_BIT_FREERUN   1
`define MBCD_BIT_SYSTEM_CLOCK_EN 2
`define MBCD_DCS_LO        4
`define MBCD_DCS_HI        7

// Reset values
`define MBCD_RST_CTRL      16'h0000
`define MBCD_RST_VSEL      16'h0000
`define MBCD_RST_IRQCFG    16'h0000
`define MBCD_RST_MASK      16'h0000
`define MBCD_RST_CLKCFG    16'h0000

// Timing: measurement period and consecutive-hit count
`define MBCD_MEAS_NS       1000
`define MBCD_CLK_NS        25
`define MBCD_MEAS_CYC      (`MBCD_MEAS_NS / `MBCD_CLK_NS)
`define MBCD_HOOK_HITS     10
`define MBCD_INS_HITS      4

`endif

//--- rtl/mbcd_pkg.sv
// Types shared by the bias detect block
package mbcd_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mbcd_req_s;

  // Detector state per monitor
  typedef enum logic [0:0] {
    DET_IDLE,
    DET_ACTIVE
  } mbcd_det_e;

  // Bias ratio codes, ratio of the analogue supply
  typedef enum logic [2:0] {
    RATIO_9_10,
    RATIO_10_9,
    RATIO_7_6,
    RATIO_4_3,
    RATIO_3_2
  } mbcd_ratio_e;

endpackage

//--- rtl/mbcd_top.sv
// Mic bias control, current detect filtering and interrupt logic
`timescale 1ns/1ps
`include "mbcd_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Bias output driven only while enable set
// - Bias select decodes to five supply ratios
// - Both current monitors run only when enabled
// - Insertion threshold from bits 6:4
// - Hook threshold from bits 3:2
// - Threshold crossings become interrupt events
// - Both detect states offered on GPIO
// - Hysteresis: separate set and clear thresholds
// - Hook event after ten consecutive measurements
// - Insertion polarity picks insert or removal
// - Hook polarity picks press or release
// - Insertion detection filtered, bounded delay
// - GPIO insertion state lags interrupt by one cycle
// - Filter runs only when clocking conditions hold
// - Events during clock stop reported later
module mbcd_top (
  input  wire logic        CORE_CLK,    // 40 MHz core clock
  input  wire logic        SRST,        // Synchronous reset, active high
  input  wire logic [7:0]  REG_ADDR,    // Register word index
  input  wire logic [15:0] REG_WDATA,   // Write data
  input  wire logic        REG_WR,      // Write strobe
  input  wire logic        REG_RD,      // Read strobe
  output logic      [15:0] REG_RDATA,   // Read data, cycle after strobe
  input  wire logic        INS_CMP_HI,  // Comparator: current above insertion set level
  input  wire logic        INS_CMP_LO,  // Comparator: current above insertion clear level
  input  wire logic        SHT_CMP_HI,  // Comparator: current above hook set level
  input  wire logic        SHT_CMP_LO,  // Comparator: current above hook clear level
  output logic             BIAS_OUT_EN, // Enables the bias output driver
  output logic [2:0]       BIAS_RATIO,  // Decoded ratio code to the bias generator
  output logic             DET_EN,      // Powers both current monitors
  output logic [2:0]       INS_THR,     // Insertion threshold code to analogue
  output logic [1:0]       SHT_THR,     // Hook threshold code to analogue
  output logic             GPIO_INS,    // Filtered insertion state for GPIO
  output logic             GPIO_HOOK,   // Filtered hook state for GPIO
  output logic             IRQ          // Level interrupt, unmasked status set
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and internal signals
  mbcd_pkg::mbcd_req_s req;           // Bundled register request
  logic [15:0] ctrl_ff;               // Primary control register
  logic [15:0] vsel_ff;               // Voltage select register
  logic [15:0] irqcfg_ff;             // Polarity bits
  logic [15:0] mask_ff;               // Interrupt mask
  logic [15:0] clkcfg_ff;             // Clocking conditions
  logic [1:0]  status_ff;             // Sticky interrupt status
  logic [1:0]  ins_sync_ff [2];       // Insertion comparator synchroniser
  logic [1:0]  sht_sync_ff [2];       // Hook comparator synchroniser
  logic [5:0]  tick_cnt_ff;           // Measurement period divider
  logic        meas_tick_ff;          // One-cycle measurement enable
  logic [3:0]  ins_cnt_ff;            // Insertion consecutive-hit counter
  logic [3:0]  sht_cnt_ff;            // Hook consecutive-hit counter
  mbcd_pkg::mbcd_det_e ins_state_ff;  // Filtered insertion state
  mbcd_pkg::mbcd_det_e sht_state_ff;  // Filtered hook state
  logic        ins_raw;               // Insertion level with hysteresis
  logic        sht_raw;               // Hook level with hysteresis
  logic        filt_run;              // Detect enabled and clocking conditions all met
  logic        ins_evt;               // Insertion status set pulse
  logic        sht_evt;               // Hook status set pulse
  logic [1:0]  nxt_status;            // Next sticky status

  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register writes
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      ctrl_ff   <= `MBCD_RST_CTRL;
      vsel_ff   <= `MBCD_RST_VSEL;
      irqcfg_ff <= `MBCD_RST_IRQCFG;
      mask_ff   <= `MBCD_RST_MASK;
      clkcfg_ff <= `MBCD_RST_CLKCFG;
    end
    else if (req.wr)
    begin
      case (req.addr)
        `MBCD_OFF_CTRL:   ctrl_ff   <= {9'h000, req.wdata[6:0]};
        `MBCD_OFF_VSEL:   vsel_ff   <= {13'h0000, req.wdata[2:0]};
        `MBCD_OFF_IRQCFG: irqcfg_ff <= {14'h0000, req.wdata[1:0]};
        `MBCD_OFF_MASK:   mask_ff   <= {14'h0000, req.wdata[1:0]};
        `MBCD_OFF_CLKCFG: clkcfg_ff <= {8'h00, req.wdata[7:4], 1'b0, req.wdata[2:0]};
        default:          ;  // Unmapped and read-only offsets ignore writes
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST || !req.rd)
    begin
      REG_RDATA <= 16'h0000;
    end
    else
    begin
      case (req.addr)
        `MBCD_OFF_CTRL:   REG_RDATA <= ctrl_ff;
        `MBCD_OFF_VSEL:   REG_RDATA <= vsel_ff;
        `MBCD_OFF_IRQCFG: REG_RDATA <= irqcfg_ff;
        `MBCD_OFF_STATUS: REG_RDATA <= {14'h0000, status_ff};
        `MBCD_OFF_MASK:   REG_RDATA <= mask_ff;
        `MBCD_OFF_CLKCFG: REG_RDATA <= clkcfg_ff;
        `MBCD_OFF_STATE:  REG_RDATA <= {14'h0000, GPIO_HOOK, GPIO_INS};
        default:          REG_RDATA <= 16'h0000;  // Unmapped reads as zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analogue control outputs, registered
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      BIAS_OUT_EN <= 1'b0;
      DET_EN      <= 1'b0;
      INS_THR     <= 3'h0;
      SHT_THR     <= 2'h0;
    end
    else
    begin
      BIAS_OUT_EN <= ctrl_ff[`MBCD_BIT_BIAS_EN];
      DET_EN      <= ctrl_ff[`MBCD_BIT_DET_EN];
      INS_THR     <= ctrl_ff[`MBCD_INS_HI:`MBCD_INS_LO];
      SHT_THR     <= ctrl_ff[`MBCD_SHT_HI:`MBCD_SHT_LO];
    end
  end

  // Ratio decode: every code from 100 up folds onto the top ratio
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      BIAS_RATIO <= mbcd_pkg::RATIO_9_10;
    end
    else
    begin
      case (vsel_ff[2:0])
        3'h0:    BIAS_RATIO <= mbcd_pkg::RATIO_9_10;
        3'h1:    BIAS_RATIO <= mbcd_pkg::RATIO_10_9;
        3'h2:    BIAS_RATIO <= mbcd_pkg::RATIO_7_6;
        3'h3:    BIAS_RATIO <= mbcd_pkg::RATIO_4_3;
        default: BIAS_RATIO <= mbcd_pkg::RATIO_3_2;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers; first stage is read only by the second
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      ins_sync_ff[0] <= 2'h0;
      ins_sync_ff[1] <= 2'h0;
      sht_sync_ff[0] <= 2'h0;
      sht_sync_ff[1] <= 2'h0;
    end
    else
    begin
      ins_sync_ff[0] <= {INS_CMP_HI, INS_CMP_LO};
      ins_sync_ff[1] <= ins_sync_ff[0];
      sht_sync_ff[0] <= {SHT_CMP_HI, SHT_CMP_LO};
      sht_sync_ff[1] <= sht_sync_ff[0];
    end
  end

  // Hysteresis: set above high level, hold until below low level
  assign ins_raw = (ins_state_ff == mbcd_pkg::DET_ACTIVE) ?
                   ins_sync_ff[1][0] : ins_sync_ff[1][1];
  assign sht_raw = (sht_state_ff == mbcd_pkg::DET_ACTIVE) ?
                   sht_sync_ff[1][0] : sht_sync_ff[1][1];

  // Filter clock gate; comparators keep their level while stopped, so a
  // change made during a stop is picked up on the first tick after it
  assign filt_run = ctrl_ff[`MBCD_BIT_DET_EN] &&
                    (clkcfg_ff[`MBCD_BIT_MCLK_OK] || clkcfg_ff[`MBCD_BIT_FREERUN]) &&
                    clkcfg_ff[`MBCD_BIT_SYSTEM_CLOCK_EN] &&
                    (|clkcfg_ff[`MBCD_DCS_HI:`MBCD_DCS_LO]);

  //////////////////////////////////////////////////////////////////////////////
  // Measurement-rate divider
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST || !filt_run)
    begin
      tick_cnt_ff  <= 6'h00;
      meas_tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff == 6'(`MBCD_MEAS_CYC - 1))
    begin
      tick_cnt_ff  <= 6'h00;
      meas_tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff  <= tick_cnt_ff + 6'h01;
      meas_tick_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Insertion filter: band-limited by a short consecutive count
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST || !ctrl_ff[`MBCD_BIT_DET_EN])
    begin
      ins_cnt_ff   <= 4'h0;
      ins_state_ff <= mbcd_pkg::DET_IDLE;
    end
    else if (meas_tick_ff)
    begin
      if (ins_raw == (ins_state_ff == mbcd_pkg::DET_ACTIVE))
      begin
        ins_cnt_ff <= 4'h0;                               // Agrees with state
      end
      else if (ins_cnt_ff == 4'(`MBCD_INS_HITS - 1))
      begin
        ins_cnt_ff   <= 4'h0;
        ins_state_ff <= ins_raw ? mbcd_pkg::DET_ACTIVE : mbcd_pkg::DET_IDLE;
      end
      else
      begin
        ins_cnt_ff <= ins_cnt_ff + 4'h1;
      end
    end
  end

  // Hook filter: ten consecutive measurements, any miss restarts
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST || !ctrl_ff[`MBCD_BIT_DET_EN])
    begin
      sht_cnt_ff   <= 4'h0;
      sht_state_ff <= mbcd_pkg::DET_IDLE;
    end
    else if (meas_tick_ff)
    begin
      if (sht_raw == (sht_state_ff == mbcd_pkg::DET_ACTIVE))
      begin
        sht_cnt_ff <= 4'h0;
      end
      else if (sht_cnt_ff == 4'(`MBCD_HOOK_HITS - 1))
      begin
        sht_cnt_ff   <= 4'h0;
        sht_state_ff <= sht_raw ? mbcd_pkg::DET_ACTIVE : mbcd_pkg::DET_IDLE;
      end
      else
      begin
        sht_cnt_ff <= sht_cnt_ff + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events: filtered state changes on the next edge, in the direction the polarity selects
  // Gated by detect enable: a tick left over from the cycle in which detect
  // was switched off must not latch an event the filter never takes
  assign ins_evt = ctrl_ff[`MBCD_BIT_DET_EN] && meas_tick_ff &&
                   ins_raw != (ins_state_ff == mbcd_pkg::DET_ACTIVE) &&
                   ins_cnt_ff == 4'(`MBCD_INS_HITS - 1) &&
                   (ins_raw != irqcfg_ff[`MBCD_BIT_INS]);
  assign sht_evt = ctrl_ff[`MBCD_BIT_DET_EN] && meas_tick_ff &&
                   sht_raw != (sht_state_ff == mbcd_pkg::DET_ACTIVE) &&
                   sht_cnt_ff == 4'(`MBCD_HOOK_HITS - 1) &&
                   (sht_raw != irqcfg_ff[`MBCD_BIT_HOOK]);

  // Sticky status: set wins over a write-one clear in the same cycle
  always_comb
  begin
    nxt_status = status_ff;
    if (req.wr && req.addr == `MBCD_OFF_STATUS)
    begin
      nxt_status = status_ff & ~req.wdata[1:0];
    end
    nxt_status = nxt_status | {sht_evt, ins_evt};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      status_ff <= 2'h0;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt and GPIO outputs; GPIO follows the filtered state only
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      IRQ       <= 1'b0;
      GPIO_INS  <= 1'b0;
      GPIO_HOOK <= 1'b0;
    end
    else
    begin
      IRQ       <= |(nxt_status & mask_ff[1:0]);
      GPIO_INS  <= (ins_state_ff == mbcd_pkg::DET_ACTIVE);
      GPIO_HOOK <= (sht_state_ff == mbcd_pkg::DET_ACTIVE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Hook filter at its tenth disagreeing measurement, monitors on
  sequence hook_change_s;
    ctrl_ff[`MBCD_BIT_DET_EN] && meas_tick_ff &&
      sht_raw != (sht_state_ff == mbcd_pkg::DET_ACTIVE) && sht_cnt_ff == 4'h9;
  endsequence

  bias_enable_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 BIAS_OUT_EN == $past(ctrl_ff[0]))
    else $error("bias enable does not follow control bit");
  ratio_fold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    vsel_ff[2] |=> BIAS_RATIO == mbcd_pkg::RATIO_3_2)
    else $error("high select codes not folded");
  // Divider must be quiet on the edge after detect goes off
  det_gate_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !ctrl_ff[1] |=> !meas_tick_ff)
    else $error("filter ran with detect off");
  // Same for any missing clocking condition
  clk_gate_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !filt_run |=> !meas_tick_ff)
    else $error("filter ran with clocking unmet");
  thr_out_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 INS_THR == $past(ctrl_ff[6:4]) && SHT_THR == $past(ctrl_ff[3:2]))
    else $error("threshold outputs wrong");
  hook_count_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(sht_state_ff == mbcd_pkg::DET_ACTIVE) |-> $past(sht_cnt_ff) == 4'h9)
    else $error("hook state changed before ten measurements");
  // Insertion filter takes four disagreeing measurements
  ins_count_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(ins_state_ff == mbcd_pkg::DET_ACTIVE) |-> $past(ins_cnt_ff) == 4'h3)
    else $error("insertion state changed too early");
  hook_event_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (hook_change_s ##0 (sht_raw != irqcfg_ff[1])) |=> status_ff[1])
    else $error("hook event not latched");
  // Status one edge after the event, GPIO one edge later still
  ins_event_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ins_evt |=> status_ff[0] ##1 GPIO_INS == $past(ins_raw, 2))
    else $error("insertion event not latched");
  gpio_follow_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 GPIO_HOOK == $past(sht_state_ff == mbcd_pkg::DET_ACTIVE))
    else $error("hook pin does not follow filtered state");
  miss_reset_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    meas_tick_ff && sht_raw == (sht_state_ff == mbcd_pkg::DET_ACTIVE) |=> sht_cnt_ff == 4'h0)
    else $error("hook counter not restarted");
  sticky_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    status_ff[0] && !(req.wr && req.addr == 8'h09 && req.wdata[0]) |=> status_ff[0])
    else $error("status bit lost without clear");
  // Registered level lags a mask write by one cycle, so the mask is
  // taken from the edge before
  irq_level_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 IRQ == |(status_ff & $past(mask_ff[1:0])))
    else $error("interrupt level wrong");

endmodule

//--- tb/mbcd_mic_model.sv
// Accessory on the bias pin, seen through its current comparators
`timescale 1ns/1ps
module mbcd_mic_model (
  input  wire logic        det_en,  // Monitors powered
  input  wire logic [2:0]  ins_thr, // Insertion level code
  input  wire logic [1:0]  sht_thr, // Hook level code
  input  wire logic [11:0] cur_ua,  // Current drawn by the accessory, uA
  output logic             ins_hi,  // Above insertion set level
  output logic             ins_lo,  // Above insertion clear level
  output logic             sht_hi,  // Above hook set level
  output logic             sht_lo   // Above hook clear level
);
  //////////////////////////////////////////////////////////////////////////////
  logic [11:0] ins_set; // Insertion set level, uA
  logic [11:0] sht_set; // Hook set level, uA

  // Evenly stepped levels, clear level below set level
  always_comb
  begin
    ins_set = 12'h046 + 12'h0BE * 12'(ins_thr);
    sht_set = 12'h208 + 12'h168 * 12'(sht_thr);
    // Unpowered comparators read low, never a stale level
    ins_hi  = det_en && (cur_ua > ins_set);
    ins_lo  = det_en && (cur_ua > ins_set - 12'h014);
    sht_hi  = det_en && (cur_ua > sht_set);
    sht_lo  = det_en && (cur_ua > sht_set - 12'h028);
  end
endmodule

//--- tb/mbcd_top_tb.sv
// Self-checking bench for the bias detect block
`timescale 1ns/1ps
`include "mbcd_cfg.svh"
module mbcd_top_tb;
  logic        clk      = 1'b0;     // Core clock
  logic        srst     = 1'b1;     // Reset
  logic [7:0]  addr     = 8'h00;    // Register index
  logic [15:0] wdata    = 16'h0000; // Write data
  logic        wr       = 1'b0;     // Write strobe
  logic        rd       = 1'b0;     // Read strobe
  logic [11:0] cur_ua   = 12'h000;  // Accessory current, uA
  logic [15:0] rdata;               // Read data
  logic        ih, il, sh, sl;      // Comparator levels
  logic        bias_en, det_en;     // Enables to analogue
  logic        g_ins, g_hook, irq;  // Detect states and interrupt
  logic [2:0]  ratio, ins_thr;      // Ratio and insertion codes
  logic [1:0]  sht_thr;             // Hook code
  int          bad_count = 0;       // Mismatches
  int          total_checks = 0;    // Comparisons
  int          n;                   // Cycles waited
  logic [7:0]  offs [8] = '{`MBCD_OFF_CTRL, `MBCD_OFF_VSEL, `MBCD_OFF_IRQCFG,
    `MBCD_OFF_STATUS, `MBCD_OFF_MASK, `MBCD_OFF_CLKCFG, `MBCD_OFF_STATE, 8'h20};

  always #12.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  mbcd_top u_mbcd_top (
    .CORE_CLK    (clk),
    .SRST        (srst),
    .REG_ADDR    (addr),
    .REG_WDATA   (wdata),
    .REG_WR      (wr),
    .REG_RD      (rd),
    .REG_RDATA   (rdata),
    .INS_CMP_HI  (ih),
    .INS_CMP_LO  (il),
    .SHT_CMP_HI  (sh),
    .SHT_CMP_LO  (sl),
    .BIAS_OUT_EN (bias_en),
    .BIAS_RATIO  (ratio),
    .DET_EN      (det_en),
    .INS_THR     (ins_thr),
    .SHT_THR     (sht_thr),
    .GPIO_INS    (g_ins),
    .GPIO_HOOK   (g_hook),
    .IRQ         (irq)
  );

  mbcd_mic_model u_mbcd_mic_model (
    .det_en  (det_en),
    .ins_thr (ins_thr),
    .sht_thr (sht_thr),
    .cur_ua  (cur_ua),
    .ins_hi  (ih),
    .ins_lo  (il),
    .sht_hi  (sh),
    .sht_lo  (sl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data sampled in the following cycle only
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check("rdata", rdata, exp);
  endtask

  // Let cycles pass, then sample settled outputs
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Change the accessory current on an edge
  task automatic set_cur(input logic [11:0] v);
    @(posedge clk);
    cur_ua <= v;
  endtask

  // Host debounce: level must be seen on two edges in a row
  task automatic wait_lvl(input logic hook, input logic val, input int lim);
    logic seen;
    logic prev;
    prev = 1'b0;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      seen = ((hook ? g_hook : g_ins) === val);
      if (seen && prev)
        return;
      prev = seen;
    end
    check("wait", 16'h0001, 16'h0000);
    results();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    reg_wr(`MBCD_OFF_STATE, 16'hFFFF);
    reg_wr(8'h20, 16'hFFFF);
    reg_wr(`MBCD_OFF_STATUS, 16'hFFFF);
    foreach (offs[i])
      reg_chk(offs[i], 16'h0000);
    check("outs", {3'h0, bias_en, det_en, g_ins, g_hook, irq, ratio, ins_thr, sht_thr},
      16'h0000);
    reg_wr(`MBCD_OFF_CTRL, 16'h0001);
    idle(1);
    check("bias_en", {15'h0000, bias_en}, 16'h0001);
    for (int s = 0; s < 8; s++)
    begin
      reg_wr(`MBCD_OFF_VSEL, 16'(s));
      idle(1);
      check("ratio", {13'h0000, ratio}, (s > 3) ? 16'h0004 : 16'(s));
    end
    reg_wr(`MBCD_OFF_CTRL, 16'h0074);
    idle(1);
    check("thr", {9'h000, bias_en, det_en, ins_thr, sht_thr}, 16'h001D);
    // Insertion while the filter clock is missing
    reg_wr(`MBCD_OFF_MASK, 16'h0003);
    reg_wr(`MBCD_OFF_CLKCFG, 16'h0014);
    reg_wr(`MBCD_OFF_CTRL, 16'h0002);
    set_cur(12'h12C);
    idle(400);
    check("stopped", {14'h0000, g_ins, irq}, 16'h0000);
    reg_wr(`MBCD_OFF_CLKCFG, 16'h0015);
    wait_lvl(1'b0, 1'b1, 250);
    reg_chk(`MBCD_OFF_STATUS, 16'h0001);
    check("irq", {15'h0000, irq}, 16'h0001);
    idle(100);
    reg_chk(`MBCD_OFF_STATUS, 16'h0001);
    reg_wr(`MBCD_OFF_MASK, 16'h0002);
    idle(1);
    check("irq", {15'h0000, irq}, 16'h0000);
    reg_wr(`MBCD_OFF_MASK, 16'h0003);
    reg_wr(`MBCD_OFF_STATUS, 16'h0001);
    reg_chk(`MBCD_OFF_STATUS, 16'h0000);
    // Monitors off: states drop without events
    reg_wr(`MBCD_OFF_CTRL, 16'h0000);
    idle(300);
    check("off", {13'h0000, det_en, g_ins, irq}, 16'h0000);
    reg_wr(`MBCD_OFF_CTRL, 16'h0002);
    reg_wr(`MBCD_OFF_CLKCFG, 16'h0016);
    wait_lvl(1'b0, 1'b1, 250);
    reg_wr(`MBCD_OFF_STATUS, 16'h0001);
    idle(200);
    // Removal polarity
    reg_wr(`MBCD_OFF_IRQCFG, 16'h0001);
    set_cur(12'h000);
    wait_lvl(1'b0, 1'b0, 250);
    reg_chk(`MBCD_OFF_STATUS, 16'h0001);
    reg_wr(`MBCD_OFF_STATUS, 16'h0001);
    set_cur(12'h12C);
    wait_lvl(1'b0, 1'b1, 250);
    reg_chk(`MBCD_OFF_STATUS, 16'h0000);
    // Hook press broken after eight measurements, then held
    reg_wr(`MBCD_OFF_IRQCFG, 16'h0000);
    set_cur(12'h320);
    idle(320);
    set_cur(12'h12C);
    idle(80);
    check("hook", {15'h0000, g_hook}, 16'h0000);
    set_cur(12'h320);
    wait_lvl(1'b1, 1'b1, 500);
    check("hook_n", {15'h0000, (n > 359 && n < 451)}, 16'h0001);
    reg_chk(`MBCD_OFF_STATUS, 16'h0002);
    check("irq", {15'h0000, irq}, 16'h0001);
    reg_wr(`MBCD_OFF_STATUS, 16'h0002);
    // Between clear and set levels the press holds
    set_cur(12'h1F4);
    idle(600);
    check("hyst", {15'h0000, g_hook}, 16'h0001);
    reg_wr(`MBCD_OFF_IRQCFG, 16'h0002);
    set_cur(12'h12C);
    wait_lvl(1'b1, 1'b0, 500);
    reg_chk(`MBCD_OFF_STATUS, 16'h0002);
    reg_chk(`MBCD_OFF_STATE, 16'h0001);
    results();
  end
endmodule
